/* shared/jtag_tap_params.svh */
// Constants for the boundary-scan test access port
`ifndef JTAG_TAP_PARAMS_SVH
`define JTAG_TAP_PARAMS_SVH

// ==========================================
// Instruction register
`define JT_IR_W 4
`define JT_IR_CAPTURE 4'h1
`define JT_OP_EXTEST 4'h0
`define JT_OP_SAMPLE 4'h1
`define JT_OP_IDCODE 4'h2
`define JT_OP_DEBUG 4'h8
`define JT_OP_BYPASS 4'hF

// ==========================================
// Debug mailbox layout
`define JT_MBX_W 38
`define JT_MBX_DATA_HI 37
`define JT_MBX_DATA_LO 6
`define JT_MBX_CMD_HI 5
`define JT_MBX_CMD_LO 2
`define JT_MBX_PEND_BIT 1
`define JT_MBX_FIN_BIT 0

// ==========================================
// Identification word
`define JT_ID_W 32
`define JT_ID_VER_HI 31
`define JT_ID_VER_LO 28
// Arbitrary neutral part and maker code
`define JT_ID_PART 28'h0123451

// ==========================================
// Boundary chain, index 0 nearest serial out
`define JT_BSR_W 21
`define JT_BC_TMR_OUT 0
`define JT_BC_TMR_CTL 1
`define JT_BC_GPD_IN 2
`define JT_BC_GPD_OUT 3
`define JT_BC_GPD_CTL 4
`define JT_BC_ADDR_LO 5
`define JT_BC_ADDR_HI 17
`define JT_BC_BANK_LO 18
`define JT_BC_BANK_HI 19
`define JT_BC_MEM_CTL 20

`endif

/* shared/jtag_tap_pkg.sv */
// Types shared by the test access port files
package jtag_tap_pkg;

	// ==========================================
	// Controller states, Gray along the scan path
	typedef enum logic [3:0] {
		TAP_RESET = 4'h0,
		TAP_IDLE = 4'h1,
		TAP_SEL_DR = 4'h3,
		TAP_CAP_DR = 4'h2,
		TAP_SHIFT_DR = 4'h6,
		TAP_EX1_DR = 4'h7,
		TAP_PAUSE_DR = 4'h5,
		TAP_EX2_DR = 4'h4,
		TAP_UPD_DR = 4'hC,
		TAP_SEL_IR = 4'hD,
		TAP_CAP_IR = 4'hF,
		TAP_SHIFT_IR = 4'hE,
		TAP_EX1_IR = 4'hA,
		TAP_PAUSE_IR = 4'hB,
		TAP_EX2_IR = 4'h9,
		TAP_UPD_IR = 4'h8
	} tap_state_t;

endpackage : jtag_tap_pkg

/* rtl/tap_state_machine.sv */
// Sixteen-state test controller clocked by the scan clock
`timescale 1ns/1ps
module tap_state_machine (
	// Scan link
	input wire logic tck,
	input wire logic trst_n,
	input wire logic tms,
	// State
	output jtag_tap_pkg::tap_state_t state_q
);

	// ==========================================
	// Next state
	function automatic jtag_tap_pkg::tap_state_t tap_next(
		input jtag_tap_pkg::tap_state_t s,
		input logic m
	);
		case (s)
			jtag_tap_pkg::TAP_RESET: tap_next = m ? jtag_tap_pkg::TAP_RESET : jtag_tap_pkg::TAP_IDLE;
			jtag_tap_pkg::TAP_IDLE: tap_next = m ? jtag_tap_pkg::TAP_SEL_DR : jtag_tap_pkg::TAP_IDLE;
			jtag_tap_pkg::TAP_SEL_DR: tap_next = m ? jtag_tap_pkg::TAP_SEL_IR : jtag_tap_pkg::TAP_CAP_DR;
			jtag_tap_pkg::TAP_CAP_DR: tap_next = m ? jtag_tap_pkg::TAP_EX1_DR : jtag_tap_pkg::TAP_SHIFT_DR;
			jtag_tap_pkg::TAP_SHIFT_DR: tap_next = m ? jtag_tap_pkg::TAP_EX1_DR : jtag_tap_pkg::TAP_SHIFT_DR;
			jtag_tap_pkg::TAP_EX1_DR: tap_next = m ? jtag_tap_pkg::TAP_UPD_DR : jtag_tap_pkg::TAP_PAUSE_DR;
			jtag_tap_pkg::TAP_PAUSE_DR: tap_next = m ? jtag_tap_pkg::TAP_EX2_DR : jtag_tap_pkg::TAP_PAUSE_DR;
			jtag_tap_pkg::TAP_EX2_DR: tap_next = m ? jtag_tap_pkg::TAP_UPD_DR : jtag_tap_pkg::TAP_SHIFT_DR;
			jtag_tap_pkg::TAP_UPD_DR: tap_next = m ? jtag_tap_pkg::TAP_SEL_DR : jtag_tap_pkg::TAP_IDLE;
			jtag_tap_pkg::TAP_SEL_IR: tap_next = m ? jtag_tap_pkg::TAP_RESET : jtag_tap_pkg::TAP_CAP_IR;
			jtag_tap_pkg::TAP_CAP_IR: tap_next = m ? jtag_tap_pkg::TAP_EX1_IR : jtag_tap_pkg::TAP_SHIFT_IR;
			jtag_tap_pkg::TAP_SHIFT_IR: tap_next = m ? jtag_tap_pkg::TAP_EX1_IR : jtag_tap_pkg::TAP_SHIFT_IR;
			jtag_tap_pkg::TAP_EX1_IR: tap_next = m ? jtag_tap_pkg::TAP_UPD_IR : jtag_tap_pkg::TAP_PAUSE_IR;
			jtag_tap_pkg::TAP_PAUSE_IR: tap_next = m ? jtag_tap_pkg::TAP_EX2_IR : jtag_tap_pkg::TAP_PAUSE_IR;
			jtag_tap_pkg::TAP_EX2_IR: tap_next = m ? jtag_tap_pkg::TAP_UPD_IR : jtag_tap_pkg::TAP_SHIFT_IR;
			jtag_tap_pkg::TAP_UPD_IR: tap_next = m ? jtag_tap_pkg::TAP_SEL_DR : jtag_tap_pkg::TAP_IDLE;
			default: tap_next = jtag_tap_pkg::TAP_RESET;
		endcase
	endfunction : tap_next

	// ==========================================
	// State register
	// rising edge only
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			state_q <= jtag_tap_pkg::TAP_RESET;
		end else begin
			state_q <= tap_next(state_q, tms);
		end
	end

endmodule : tap_state_machine

/* rtl/debug_mailbox_cpu.sv */
// CPU-side half of the serial debug mailbox
`timescale 1ns/1ps
module debug_mailbox_cpu (
	// System clock
	input wire logic sys_clk,
	input wire logic sys_rst,
	// From scan domain, word stable while toggle settles
	input wire logic cmd_tgl,
	input wire logic [35:0] cmd_word,
	// CPU side
	input wire logic cpu_done,
	input wire logic [31:0] cpu_resp,
	output logic cpu_cmd_valid_q,
	output logic [3:0] cpu_cmd_q,
	output logic [31:0] cpu_data_q,
	// Status toward scan domain
	output logic pending_q,
	output logic finished_q,
	output logic [31:0] resp_q
);

	logic tgl_s1_q;
	logic tgl_s2_q;
	logic tgl_s3_q;
	logic evt;

	// ==========================================
	// Toggle crossing
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
		end else begin
			tgl_s1_q <= cmd_tgl;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
		end
	end

	assign evt = tgl_s2_q ^ tgl_s3_q;

	// ==========================================
	// Command delivery
	// payload and command to CPU
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cpu_cmd_valid_q <= 1'b0;
			cpu_cmd_q <= 4'h0;
			cpu_data_q <= 32'h0000_0000;
		end else begin
			cpu_cmd_valid_q <= evt;
			if (evt) begin
				cpu_cmd_q <= cmd_word[3:0];
				cpu_data_q <= cmd_word[35:4];
			end
		end
	end

	// ==========================================
	// Handshake flags, a set beats a clear
	// pending and finished flags
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pending_q <= 1'b0;
			finished_q <= 1'b0;
		end else begin
			pending_q <= evt | (pending_q & ~cpu_done);
			finished_q <= cpu_done | (finished_q & ~evt);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			resp_q <= 32'h0000_0000;
		end else if (cpu_done) begin
			resp_q <= cpu_resp;
		end
	end

endmodule : debug_mailbox_cpu

/* rtl/jtag_tap_scan_controller.sv */
// Boundary-scan test access port with debug mailbox and identification word
//
// Overview of operation
// - Chain starts at memory output-enable control, ends at timer output zero.
// - Each control cell enables pads after it up to the next control.
// - Bidirectional pads put the output cell nearer serial in.
// - Debug mailbox is 38 bits: payload 37..6, command 5..2.
// - Mailbox bit 1 shows command pending, bit 0 command finished.
// - Identification: fixed code in low 28 bits, revision substep above.
// - Controller advances only on rising scan clock, steered by mode select.
// - Five high mode-select edges or test reset low reach reset state.
// - Reset state loads identification instruction and disables test logic.
// - No power-good reset; test reset pulled low holds controller reset.
// - Idle holds with mode low, goes data-select when high.
// - Data-select: low captures data, high goes instruction-select.
// - Capture samples pins only for boundary instructions; others load identification, mailbox status or bypass zero.
// - Shift-data moves selected register one stage per rising edge.
// - Exit1-data: high updates, low pauses; registers hold.
// - Pause-data holds shifting while low, high goes exit2.
// - Exit2-data: high updates, low resumes shifting.
// - Boundary parallel latch loads on falling edge of update only.
// - Update-data: high to data-select, low to idle; shift stages hold.
// - Instruction-select: low captures instruction, high returns to reset.
// - Instruction capture loads pattern 0001.
// - Shift-instruction moves instruction stages one per rising edge.
// - Instruction exit, pause and exit2 steps mirror the data path.
// - Update-instruction latches new instruction on the falling edge.
`timescale 1ns/1ps
`include "jtag_tap_params.svh"
module jtag_tap_scan_controller (
	// System clock
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Scan link
	input wire logic tck,
	input wire logic trst_n,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo_q,
	output logic tdo_oe_n_q,
	// Observed pad values
	input wire logic core_mem_oe,
	input wire logic [1:0] mem_bank_select,
	input wire logic [12:0] mem_row_col_addr,
	input wire logic core_gpd_oe,
	input wire logic core_gpd_out,
	input wire logic pad_gpd_in,
	input wire logic core_tmr_oe,
	input wire logic timer_out_zero,
	input wire logic [3:0] revision_substep,
	// Boundary drive to pads
	output logic test_mode_q,
	output logic tst_mem_oe_q,
	output logic [1:0] tst_bank_q,
	output logic [12:0] tst_addr_q,
	output logic tst_gpd_oe_q,
	output logic tst_gpd_out_q,
	output logic tst_tmr_oe_q,
	output logic tst_tmr_out_q,
	// CPU debug side
	input wire logic cpu_done,
	input wire logic [31:0] cpu_resp,
	output logic cpu_cmd_valid_q,
	output logic [3:0] cpu_cmd_q,
	output logic [31:0] cpu_data_q
);

	jtag_tap_pkg::tap_state_t state_q;

	logic [`JT_IR_W-1:0] ir_q;
	logic [`JT_IR_W-1:0] ir_sh_q;
	logic byp_q;
	logic [`JT_ID_W-1:0] id_sh_q;
	logic [`JT_BSR_W-1:0] bsr_sh_q;
	logic [`JT_MBX_W-1:0] mbx_sh_q;

	logic [`JT_BSR_W-1:0] obs_s1_q;
	logic [`JT_BSR_W-1:0] obs_s2_q;
	logic [`JT_BSR_W-1:0] obs_s3_q;
	logic [`JT_BSR_W-1:0] obs_q;
	logic [`JT_BSR_W-1:0] obs_raw;

	logic [3:0] rev_s1_q;
	logic [3:0] rev_s2_q;
	logic [3:0] rev_s3_q;
	logic [3:0] rev_q;

	logic mbx_tgl_q;
	logic [35:0] mbx_cmd_q;
	logic pend_s1_q;
	logic pend_s2_q;
	logic fin_s1_q;
	logic fin_s2_q;
	logic pending_sys;
	logic finished_sys;
	logic [31:0] resp_sys;

	logic sel_bsr;
	logic sel_id;
	logic sel_mbx;
	logic dr_out;

	// ==========================================
	// Instruction decode
	function automatic logic is_bsr_op(input logic [`JT_IR_W-1:0] op);
		is_bsr_op = (op == `JT_OP_EXTEST) || (op == `JT_OP_SAMPLE);
	endfunction : is_bsr_op

	always_comb begin
		sel_bsr = is_bsr_op(ir_q);
		sel_id = (ir_q == `JT_OP_IDCODE);
		sel_mbx = (ir_q == `JT_OP_DEBUG);
	end

	// ==========================================
	// Controller
	// reset comes from test reset pin only
	tap_state_machine u_fsm (
		.tck(tck),
		.trst_n(trst_n),
		.tms(tms),
		.state_q(state_q)
	);

	// ==========================================
	// Pad observation, three-flop agree filter
	// memory control cell nearest serial in
	always_comb begin
		obs_raw = '0;
		obs_raw[`JT_BC_MEM_CTL] = core_mem_oe;
		obs_raw[`JT_BC_BANK_HI:`JT_BC_BANK_LO] = mem_bank_select;
		obs_raw[`JT_BC_ADDR_HI:`JT_BC_ADDR_LO] = mem_row_col_addr;
		obs_raw[`JT_BC_GPD_CTL] = core_gpd_oe;
		obs_raw[`JT_BC_GPD_OUT] = core_gpd_out;
		obs_raw[`JT_BC_GPD_IN] = pad_gpd_in;
		obs_raw[`JT_BC_TMR_CTL] = core_tmr_oe;
		obs_raw[`JT_BC_TMR_OUT] = timer_out_zero;
	end

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			obs_s1_q <= '0;
			obs_s2_q <= '0;
			obs_s3_q <= '0;
		end else begin
			obs_s1_q <= obs_raw;
			obs_s2_q <= obs_s1_q;
			obs_s3_q <= obs_s2_q;
		end
	end

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			obs_q <= '0;
		end else begin
			obs_q <= (obs_s2_q & obs_s3_q) | (obs_q & (obs_s2_q | obs_s3_q));
		end
	end

	// Revision substep is near static
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			rev_s1_q <= 4'h0;
			rev_s2_q <= 4'h0;
			rev_s3_q <= 4'h0;
			rev_q <= 4'h0;
		end else begin
			rev_s1_q <= revision_substep;
			rev_s2_q <= rev_s1_q;
			rev_s3_q <= rev_s2_q;
			rev_q <= (rev_s2_q & rev_s3_q) | (rev_q & (rev_s2_q | rev_s3_q));
		end
	end

	// ==========================================
	// Instruction shift stages
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ir_sh_q <= `JT_IR_CAPTURE;
		end else begin
			case (state_q)
				jtag_tap_pkg::TAP_CAP_IR: begin
					ir_sh_q <= `JT_IR_CAPTURE;
				end
				jtag_tap_pkg::TAP_SHIFT_IR: begin
					ir_sh_q <= {tdi, ir_sh_q[`JT_IR_W-1:1]};
				end
				default: begin
					ir_sh_q <= ir_sh_q;
				end
			endcase
		end
	end

	// ==========================================
	// Current instruction, falling edge
	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ir_q <= `JT_OP_IDCODE;
			test_mode_q <= 1'b0;
		end else if (state_q == jtag_tap_pkg::TAP_RESET) begin
			ir_q <= `JT_OP_IDCODE;
			test_mode_q <= 1'b0;
		end else if (state_q == jtag_tap_pkg::TAP_UPD_IR) begin
			ir_q <= ir_sh_q;
			test_mode_q <= (ir_sh_q == `JT_OP_EXTEST);
		end
	end

	// ==========================================
	// Bypass and identification
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			byp_q <= 1'b0;
		end else if (state_q == jtag_tap_pkg::TAP_CAP_DR) begin
			byp_q <= 1'b0;
		end else if (state_q == jtag_tap_pkg::TAP_SHIFT_DR) begin
			byp_q <= tdi;
		end
	end

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			id_sh_q <= '0;
		end else if (sel_id && state_q == jtag_tap_pkg::TAP_CAP_DR) begin
			id_sh_q <= {rev_q, `JT_ID_PART};
		end else if (sel_id && state_q == jtag_tap_pkg::TAP_SHIFT_DR) begin
			id_sh_q <= {tdi, id_sh_q[`JT_ID_W-1:1]};
		end
	end

	// ==========================================
	// Boundary shift stages
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			bsr_sh_q <= '0;
		end else if (sel_bsr) begin
			case (state_q)
				jtag_tap_pkg::TAP_CAP_DR: begin
					bsr_sh_q <= obs_q;
				end
				jtag_tap_pkg::TAP_SHIFT_DR: begin
					bsr_sh_q <= {tdi, bsr_sh_q[`JT_BSR_W-1:1]};
				end
				default: begin
					bsr_sh_q <= bsr_sh_q;
				end
			endcase
		end
	end

	// ==========================================
	// Boundary parallel latch
	// falling edge of update only
	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tst_mem_oe_q <= 1'b0;
			tst_bank_q <= 2'h0;
			tst_addr_q <= 13'h0000;
			tst_gpd_oe_q <= 1'b0;
			tst_gpd_out_q <= 1'b0;
			tst_tmr_oe_q <= 1'b0;
			tst_tmr_out_q <= 1'b0;
		end else if (sel_bsr && state_q == jtag_tap_pkg::TAP_UPD_DR) begin
			tst_mem_oe_q <= bsr_sh_q[`JT_BC_MEM_CTL];
			tst_bank_q <= bsr_sh_q[`JT_BC_BANK_HI:`JT_BC_BANK_LO];
			tst_addr_q <= bsr_sh_q[`JT_BC_ADDR_HI:`JT_BC_ADDR_LO];
			tst_gpd_oe_q <= bsr_sh_q[`JT_BC_GPD_CTL];
			tst_gpd_out_q <= bsr_sh_q[`JT_BC_GPD_OUT];
			tst_tmr_oe_q <= bsr_sh_q[`JT_BC_TMR_CTL];
			tst_tmr_out_q <= bsr_sh_q[`JT_BC_TMR_OUT];
		end
	end

	// ==========================================
	// Debug mailbox, scan side
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			pend_s1_q <= 1'b0;
			pend_s2_q <= 1'b0;
			fin_s1_q <= 1'b0;
			fin_s2_q <= 1'b0;
		end else begin
			pend_s1_q <= pending_sys;
			pend_s2_q <= pend_s1_q;
			fin_s1_q <= finished_sys;
			fin_s2_q <= fin_s1_q;
		end
	end

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			mbx_sh_q <= '0;
		end else if (sel_mbx && state_q == jtag_tap_pkg::TAP_CAP_DR) begin
			// flags in the two low bits
			// Response is steady once finished is seen
			mbx_sh_q <= {resp_sys, mbx_cmd_q[3:0], pend_s2_q, fin_s2_q};
		end else if (sel_mbx && state_q == jtag_tap_pkg::TAP_SHIFT_DR) begin
			mbx_sh_q <= {tdi, mbx_sh_q[`JT_MBX_W-1:1]};
		end
	end

	// Word is held until the next update, so the
	// host must not post again before pending shows
	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			mbx_cmd_q <= '0;
			mbx_tgl_q <= 1'b0;
		end else if (sel_mbx && state_q == jtag_tap_pkg::TAP_UPD_DR) begin
			mbx_cmd_q <= {mbx_sh_q[`JT_MBX_DATA_HI:`JT_MBX_DATA_LO],
				mbx_sh_q[`JT_MBX_CMD_HI:`JT_MBX_CMD_LO]};
			mbx_tgl_q <= ~mbx_tgl_q;
		end
	end

	debug_mailbox_cpu u_mbx (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.cmd_tgl(mbx_tgl_q),
		.cmd_word(mbx_cmd_q),
		.cpu_done(cpu_done),
		.cpu_resp(cpu_resp),
		.cpu_cmd_valid_q(cpu_cmd_valid_q),
		.cpu_cmd_q(cpu_cmd_q),
		.cpu_data_q(cpu_data_q),
		.pending_q(pending_sys),
		.finished_q(finished_sys),
		.resp_q(resp_sys)
	);

	// ==========================================
	// Serial output, falling edge
	always_comb begin
		if (sel_bsr) begin
			dr_out = bsr_sh_q[0];
		end else if (sel_id) begin
			dr_out = id_sh_q[0];
		end else if (sel_mbx) begin
			dr_out = mbx_sh_q[0];
		end else begin
			dr_out = byp_q;
		end
	end

	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tdo_q <= 1'b0;
			tdo_oe_n_q <= 1'b1;
		end else if (state_q == jtag_tap_pkg::TAP_SHIFT_IR) begin
			tdo_q <= ir_sh_q[0];
			tdo_oe_n_q <= 1'b0;
		end else if (state_q == jtag_tap_pkg::TAP_SHIFT_DR) begin
			tdo_q <= dr_out;
			tdo_oe_n_q <= 1'b0;
		end else begin
			tdo_q <= 1'b0;
			tdo_oe_n_q <= 1'b1;
		end
	end

endmodule : jtag_tap_scan_controller

/* tb/jtag_tester_model.sv */
// Scan host model driving the test access port pins
`timescale 1ns/1ps
module jtag_tester_model (
	// Scan pins
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n,
	input wire logic tdo_q,
	input wire logic tdo_oe_n_q
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b0;
	end

	// ==========================
	// Clock pulses only inside calls; stands still between them
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#16 o = tdo_q;
		tck = 1'b1;
		#16 tck = 1'b0;
	endtask : step

	// Serial in is not meaningful here, so it toggles
	task automatic nav(input logic m);
		logic o;
		step(m, ~tdi, o);
	endtask : nav

	task automatic release_reset();
		trst_n = 1'b1;
	endtask : release_reset

	task automatic reset_tap();
		repeat (5) nav(1'b1);
		nav(1'b0);
	endtask : reset_tap

	// ==========================
	// Idle to idle scan, LSB first, optional pause mid-way
	task automatic scan(input logic ir, input int n, input logic [37:0] din, input logic pz,
		output logic [37:0] dout);
		logic o;
		dout = '0;
		nav(1'b1);
		if (ir) begin
			nav(1'b1);
		end
		nav(1'b0);
		nav(1'b0);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1 || (pz && i == n / 2), din[i], o);
			dout[i] = o;
			if (pz && i == n / 2 && i != n - 1) begin
				nav(1'b0);
				nav(1'b0);
				nav(1'b1);
				nav(1'b0);
			end
		end
		nav(1'b1);
		nav(1'b0);
	endtask : scan
endmodule : jtag_tester_model

/* tb/jtag_tap_scan_controller_properties.sv */
// Property checker for the scan port outputs
`timescale 1ns/1ps
module jtag_tap_scan_controller_checker (
	// Clocks and resets
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic tck,
	input wire logic trst_n,
	// Scan link
	input wire logic tms,
	input wire logic tdo_q,
	input wire logic tdo_oe_n_q,
	// Boundary and mode
	input logic test_mode_q,
	input logic tst_mem_oe_q,
	input logic [1:0] tst_bank_q,
	input logic [12:0] tst_addr_q,
	// CPU side
	input logic cpu_cmd_valid_q,
	input logic [3:0] cpu_cmd_q,
	input logic [31:0] cpu_data_q
);
	// ==========================
	// Scan domain
	chk_five_high_reset: assert property (@(posedge tck) disable iff (!trst_n)
		tms [*5] |-> ##2 (!test_mode_q && tdo_oe_n_q)) else $error("not reset after five high mode edges");
	chk_tdo_quiet: assert property (@(posedge tck) disable iff (!trst_n)
		tdo_oe_n_q |-> !tdo_q) else $error("serial out not quiet while disabled");
	chk_shift_entry: assert property (@(posedge tck) disable iff (!trst_n)
		!tdo_oe_n_q |-> !$past(tms)) else $error("shift entered on high mode");
	chk_shift_stay: assert property (@(posedge tck) disable iff (!trst_n)
		(!tdo_oe_n_q && !tms) |=> !tdo_oe_n_q) else $error("shift left on low mode");
	chk_shift_leave: assert property (@(posedge tck) disable iff (!trst_n)
		(!tdo_oe_n_q && tms) |=> tdo_oe_n_q) else $error("shift kept on high mode");
	chk_bound_hold: assert property (@(posedge tck) disable iff (!trst_n)
		$changed({tst_mem_oe_q, tst_bank_q, tst_addr_q}) |-> $past(tms))
		else $error("boundary latch changed outside update");
	// ==========================
	// System domain
	chk_cmd_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cpu_cmd_valid_q |=> !cpu_cmd_valid_q) else $error("command strobe longer than one cycle");
	chk_cmd_steady: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$changed({cpu_cmd_q, cpu_data_q}) |-> cpu_cmd_valid_q) else $error("command word moved without strobe");
	cov_shift: cover property (@(posedge tck) disable iff (!trst_n) $fell(tdo_oe_n_q));
	cov_extest: cover property (@(posedge tck) disable iff (!trst_n) $rose(test_mode_q));
	cov_cmd: cover property (@(posedge sys_clk) disable iff (sys_rst) cpu_cmd_valid_q);
endmodule : jtag_tap_scan_controller_checker

bind jtag_tap_scan_controller jtag_tap_scan_controller_checker u_chk (.sys_clk, .sys_rst, .tck, .trst_n,
	.tms, .tdo_q, .tdo_oe_n_q, .test_mode_q, .tst_mem_oe_q, .tst_bank_q, .tst_addr_q,
	.cpu_cmd_valid_q, .cpu_cmd_q, .cpu_data_q);

/* tb/jtag_tap_scan_controller_tb_top.sv */
// Self-checking bench for the scan port
`timescale 1ns/1ps
`include "jtag_tap_params.svh"
module jtag_tap_scan_controller_tb_top;
	logic sys_clk, sys_rst, tck, trst_n, tms, tdi, tdo_q, tdo_oe_n_q;
	logic core_mem_oe, core_gpd_oe, core_gpd_out, pad_gpd_in, core_tmr_oe, timer_out_zero;
	logic [1:0] mem_bank_select;
	logic [12:0] mem_row_col_addr;
	logic [3:0] revision_substep;
	logic test_mode_q, tst_mem_oe_q, tst_gpd_oe_q, tst_gpd_out_q, tst_tmr_oe_q, tst_tmr_out_q;
	logic [1:0] tst_bank_q;
	logic [12:0] tst_addr_q;
	logic cpu_done, cpu_cmd_valid_q;
	logic [31:0] cpu_resp, cpu_data_q;
	logic [3:0] cpu_cmd_q;
	logic [37:0] rd;
	logic [20:0] bsr;
	int failures = 0;
	int check_count = 0;
	int cmd_seen = 0;

	jtag_tap_scan_controller u_jtag_tap_scan_controller (.*);
	jtag_tester_model u_jtag_tester_model (.tck, .tms, .tdi, .trst_n, .tdo_q, .tdo_oe_n_q);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Strobe is gone before a scan returns, so count it as it passes
	always @(negedge sys_clk) begin
		if (cpu_cmd_valid_q === 1'b1) begin
			cmd_seen++;
		end
	end

	// ==========================
	// Helpers
	task automatic check(input logic [37:0] got, input logic [37:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test

	task automatic set_ir(input logic [3:0] op);
		u_jtag_tester_model.scan(1'b1, 4, {34'h0, op}, 1'b0, rd);
		check(rd, {34'h0, `JT_IR_CAPTURE});
	endtask : set_ir

	// Bounded wait for the n-th CPU command strobe; word stands after it
	task automatic wait_cmd(input int n, input logic [31:0] data);
		for (int i = 0; i < 60 && cmd_seen < n; i++) @(negedge sys_clk);
		check({1'b0, cmd_seen == n, cpu_cmd_q, cpu_data_q}, {1'b0, 1'b1, 4'h5, data});
	endtask : wait_cmd

	// ==========================
	// Tests
	initial begin
		sys_rst = 1'b1;
		cpu_done = 1'b0;
		cpu_resp = 32'h0;
		revision_substep = 4'hA;
		{core_mem_oe, mem_bank_select, mem_row_col_addr, core_gpd_oe, core_gpd_out, pad_gpd_in, core_tmr_oe,
			timer_out_zero} = 21'h0;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		sys_rst = 1'b0;
		u_jtag_tester_model.release_reset();
		u_jtag_tester_model.reset_tap();
		repeat (3) u_jtag_tester_model.nav(1'b0);
		u_jtag_tester_model.scan(1'b0, 32, 38'h0, 1'b0, rd);
		check(rd, {6'h0, 4'hA, `JT_ID_PART});
		set_ir(`JT_OP_BYPASS);
		u_jtag_tester_model.scan(1'b0, 8, 38'hA5, 1'b0, rd);
		check(rd, 38'h4A);
		for (int k = 0; k < 2; k++) begin
			@(negedge sys_clk);
			bsr = k ? 21'h0A5F3 : 21'h15A0C;
			{core_mem_oe, mem_bank_select, mem_row_col_addr, core_gpd_oe, core_gpd_out, pad_gpd_in, core_tmr_oe,
				timer_out_zero} = bsr;
			set_ir(k ? `JT_OP_EXTEST : `JT_OP_SAMPLE);
			check({37'h0, test_mode_q}, {37'h0, k[0]});
			u_jtag_tester_model.scan(1'b0, 21, {17'h0, ~bsr}, k[0], rd);
			check(rd, {17'h0, bsr});
			check({18'h0, tst_mem_oe_q, tst_bank_q, tst_addr_q, tst_gpd_oe_q, tst_gpd_out_q, tst_tmr_oe_q,
				tst_tmr_out_q}, {18'h0, ~bsr[20:3], ~bsr[1:0]});
		end
		repeat (3) u_jtag_tester_model.nav(1'b1);
		u_jtag_tester_model.nav(1'b0);
		check({37'h0, test_mode_q}, 38'h0);
		u_jtag_tester_model.scan(1'b0, 32, 38'h0, 1'b0, rd);
		check(rd, {6'h0, 4'hA, `JT_ID_PART});
		set_ir(`JT_OP_DEBUG);
		u_jtag_tester_model.scan(1'b0, 38, {32'hC0DE1234, 4'h5, 2'h0}, 1'b0, rd);
		wait_cmd(1, 32'hC0DE1234);
		repeat (2) u_jtag_tester_model.nav(1'b0);
		u_jtag_tester_model.scan(1'b0, 38, {32'h1357ACE0, 4'h5, 2'h0}, 1'b0, rd);
		check(rd, {32'h0, 4'h5, 2'h2});
		wait_cmd(2, 32'h1357ACE0);
		@(negedge sys_clk);
		cpu_resp = 32'h89AB4321;
		cpu_done = 1'b1;
		@(negedge sys_clk);
		cpu_done = 1'b0;
		repeat (2) u_jtag_tester_model.nav(1'b0);
		u_jtag_tester_model.scan(1'b0, 38, 38'h0, 1'b1, rd);
		check(rd, {32'h89AB4321, 4'h5, 2'h1});
		stop_test();
	end

	initial begin
		#100000;
		failures++;
		stop_test();
	end
endmodule : jtag_tap_scan_controller_tb_top
